// [hw/fpwm_top.sv]
// Four-channel waveform unit: APB register file, prescaler, two linear dividers and channels.
// Assumes APB3 signalling on pclk, and a level from the power manager saying the unit clock runs.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "fpwm_defines.svh"
module fpwm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic unit_clock_on,
    output logic [3:0] waveform_output,
    output logic irq
);

    // Register state and its next value.
    fpwm_pkg::fpwm_regs_type s;
    fpwm_pkg::fpwm_regs_type next_s;
    // Prescaler taps: bit k is a one-cycle tick at master clock divided by 2**k.
    logic [10:0] pre_tick;
    // Divider results, tick in the top bit and next count below.
    logic [8:0] div_res_a;
    logic [8:0] div_res_b;
    // All thirteen selectable ticks, prescaler taps then divided clocks A and B.
    logic [12:0] clk_bus;
    // Per-channel counter values and period end pulses.
    logic [3:0][15:0] chan_count;
    logic [3:0] period_end;
    // APB phase qualifiers.
    logic setup_phase;
    logic wr_done;
    logic rd_done;

    // One linear divider step; a factor of zero stops it and holds its count at zero.
    function automatic logic [8:0] fpwm_div_step(input logic [7:0] cnt, input logic [7:0] factor,
        input logic in_tick);
        if (factor == 8'h00) begin
            return 9'h000;
        end
        if (!in_tick) begin
            return {1'b0, cnt};
        end
        if (cnt >= factor - 8'h01) begin
            return {1'b1, 8'h00};
        end
        return {1'b0, cnt + 8'h01};
    endfunction : fpwm_div_step

    // Picks a channel's tick from the clock bus; unused codes give no clock.
    function automatic logic fpwm_pick(input logic [12:0] bus, input logic [3:0] sel);
        if (sel > `FPWM_SEL_CLK_B) begin
            return 1'b0;
        end
        return bus[sel];
    endfunction : fpwm_pick

    // True when the address falls in a channel block: 0x200 + ch * 0x20 + reg * 4.
    function automatic logic fpwm_is_chan(input logic [11:0] addr);
        return addr[11:9] == `FPWM_CHAN_BASE_BITS && addr[8:7] == 2'b00 && addr[1:0] == 2'b00
            && addr[4:2] <= `FPWM_CH_UPDATE;
    endfunction : fpwm_is_chan

    // Prescaler taps and the two dividers; every tap stops while the unit clock is off.
    always_comb begin
        pre_tick[0] = unit_clock_on;
        for (int k = 1; k <= `FPWM_PRE_STAGES; k++) begin
            pre_tick[k] = unit_clock_on && ((s.pre_count & 10'((1 << k) - 1)) == 10'((1 << k) - 1));
        end
        div_res_a = fpwm_div_step(s.div_count_a, s.div_a, fpwm_pick({2'b00, pre_tick}, s.pre_a));
        div_res_b = fpwm_div_step(s.div_count_b, s.div_b, fpwm_pick({2'b00, pre_tick}, s.pre_b));
        clk_bus = {div_res_b[8], div_res_a[8], pre_tick};
    end

    assign setup_phase = psel && !penable;
    assign wr_done = psel && penable && pwrite;
    assign rd_done = psel && penable && !pwrite;

    // The four channels, each fed the live settings and its own selected tick.
    for (genvar i = 0; i < 4; i++) begin : g_chan
        fpwm_channel u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .tick(fpwm_pick(clk_bus, s.clk_sel[i])),
            .cfg('{enable: s.enabled[i], center: s.center[i], polarity: s.polarity[i],
                period: s.period[i], duty: s.duty[i]}),
            .count(chan_count[i]),
            .wave(waveform_output[i]),
            .period_end(period_end[i])
        );
    end

    // Next state: counters, register writes, update loads, flags and read data.
    always_comb begin
        logic [1:0] ch;
        logic [2:0] idx;
        logic [31:0] rdata;
        logic bad;
        ch = paddr[6:5];
        idx = paddr[4:2];
        rdata = 32'h00000000;
        bad = 1'b0;
        next_s = s;
        // Counters move only while the unit clock runs, so a stop freezes them exactly.
        if (unit_clock_on) begin
            next_s.pre_count = s.pre_count + 10'h001;
        end
        next_s.div_count_a = div_res_a[7:0];
        next_s.div_count_b = div_res_b[7:0];
        // End of period: load a pending update into the chosen register.
        for (int i = 0; i < 4; i++) begin
            if (period_end[i] && s.upd_pending[i]) begin
                if (s.upd_target[i]) begin
                    next_s.period[i] = s.upd_value[i];
                end else begin
                    next_s.duty[i] = s.upd_value[i];
                end
                next_s.upd_pending[i] = 1'b0;
            end
        end
        // Reading the status register clears the flags before new events are merged in.
        if (rd_done && paddr == `FPWM_OFS_INT_STAT) begin
            next_s.int_stat = 4'h0;
        end
        // Writes are taken whether or not the unit clock runs.
        if (wr_done) begin
            if (fpwm_is_chan(paddr)) begin
                case (idx)
                    `FPWM_CH_MODE: begin
                        next_s.clk_sel[ch] = pwdata[`FPWM_CLK_SEL_LSB +: 4];
                        next_s.upd_target[ch] = pwdata[`FPWM_UPD_TGT_BIT];
                        // Polarity and alignment are locked while the channel runs.
                        if (!s.enabled[ch]) begin
                            next_s.polarity[ch] = pwdata[`FPWM_POL_BIT];
                            next_s.center[ch] = pwdata[`FPWM_CENTER_BIT];
                        end
                    end
                    `FPWM_CH_DUTY: begin
                        // Direct writes only while disabled; a running channel uses the update path.
                        if (!s.enabled[ch]) begin
                            next_s.duty[ch] = pwdata[15:0];
                        end
                    end
                    `FPWM_CH_PERIOD: begin
                        if (!s.enabled[ch]) begin
                            next_s.period[ch] = pwdata[15:0];
                        end
                    end
                    `FPWM_CH_UPDATE: begin
                        // A write in the same cycle as a load stays pending for the next period.
                        next_s.upd_value[ch] = pwdata[15:0];
                        next_s.upd_pending[ch] = 1'b1;
                    end
                    default: begin
                        next_s.upd_pending[ch] = next_s.upd_pending[ch];
                    end
                endcase
            end else begin
                case (paddr)
                    `FPWM_OFS_MODE: begin
                        next_s.div_a = pwdata[`FPWM_DIV_A_LSB +: 8];
                        next_s.pre_a = pwdata[`FPWM_PRE_A_LSB +: 4];
                        next_s.div_b = pwdata[`FPWM_DIV_B_LSB +: 8];
                        next_s.pre_b = pwdata[`FPWM_PRE_B_LSB +: 4];
                    end
                    `FPWM_OFS_ENABLE: begin
                        next_s.enabled = s.enabled | pwdata[3:0];
                    end
                    `FPWM_OFS_DISABLE: begin
                        next_s.enabled = s.enabled & ~pwdata[3:0];
                    end
                    `FPWM_OFS_INT_EN: begin
                        next_s.int_mask = s.int_mask | pwdata[3:0];
                    end
                    `FPWM_OFS_INT_DIS: begin
                        next_s.int_mask = s.int_mask & ~pwdata[3:0];
                    end
                    default: begin
                        next_s.int_mask = next_s.int_mask;
                    end
                endcase
            end
        end
        // A period end in the clearing cycle still sets its flag.
        next_s.int_stat = next_s.int_stat | period_end;
        // Read data and error are captured in the setup cycle and shown in the access cycle.
        if (fpwm_is_chan(paddr)) begin
            case (idx)
                `FPWM_CH_MODE: begin
                    rdata = 32'h00000000;
                    rdata[`FPWM_CLK_SEL_LSB +: 4] = s.clk_sel[ch];
                    rdata[`FPWM_CENTER_BIT] = s.center[ch];
                    rdata[`FPWM_POL_BIT] = s.polarity[ch];
                    rdata[`FPWM_UPD_TGT_BIT] = s.upd_target[ch];
                end
                `FPWM_CH_DUTY: begin
                    rdata = {16'h0000, s.duty[ch]};
                end
                `FPWM_CH_PERIOD: begin
                    rdata = {16'h0000, s.period[ch]};
                end
                `FPWM_CH_COUNT: begin
                    rdata = {16'h0000, chan_count[ch]};
                end
                default: begin
                    rdata = 32'h00000000;
                end
            endcase
        end else begin
            case (paddr)
                `FPWM_OFS_MODE: begin
                    rdata = {4'h0, s.pre_b, s.div_b, 4'h0, s.pre_a, s.div_a};
                end
                `FPWM_OFS_STATUS: begin
                    rdata = {28'h0000000, s.enabled};
                end
                `FPWM_OFS_INT_MASK: begin
                    rdata = {28'h0000000, s.int_mask};
                end
                `FPWM_OFS_INT_STAT: begin
                    rdata = {28'h0000000, s.int_stat};
                end
                `FPWM_OFS_ENABLE, `FPWM_OFS_DISABLE, `FPWM_OFS_INT_EN, `FPWM_OFS_INT_DIS: begin
                    rdata = 32'h00000000;
                end
                default: begin
                    bad = 1'b1;
                end
            endcase
        end
        if (setup_phase) begin
            next_s.prdata = rdata;
            next_s.pslverr = bad;
        end
    end

    // Register update; reset clears dividers, selects and every channel setting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Every access completes in its first access cycle.
    assign pready = 1'b1;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    // Level interrupt, held until the status register is read.
    assign irq = |(s.int_stat & s.int_mask);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Each period end leaves its flag set on the next cycle.
    a_flag_on_end: assert property (period_end != 4'h0 |=> (s.int_stat & $past(period_end)) == $past(period_end))
        else $error("period end did not set status flag");
    // A status read with no new event empties the flags.
    a_read_clears: assert property (rd_done && paddr == `FPWM_OFS_INT_STAT && period_end == 4'h0
        |=> s.int_stat == 4'h0 && !irq)
        else $error("status read did not clear flags");
    // Divided clock A never ticks while its factor is zero.
    a_div_off_a: assert property (s.div_a == 8'h00 |-> !clk_bus[11] ##1 s.div_count_a == 8'h00)
        else $error("divided clock A ticked with factor zero");
    // With a gated unit clock no tick fires and divider B's count holds still.
    a_gated_hold: assert property (!unit_clock_on |-> clk_bus == 13'h0000 ##1 $stable(s.div_count_b))
        else $error("clock tree moved while unit clock off");
    // Polarity written to a running channel is ignored.
    a_pol_locked: assert property (wr_done && paddr == 12'h200 && s.enabled[0] |=> $stable(s.polarity[0]))
        else $error("polarity changed while channel enabled");
    // A pending duty update lands in the duty register at the period end.
    sequence s_upd_load;
        period_end[0] && s.upd_pending[0] && !s.upd_target[0] && !(wr_done && paddr == 12'h210);
    endsequence
    a_upd_load: assert property (s_upd_load |=> s.duty[0] == $past(s.upd_value[0]) && !s.upd_pending[0])
        else $error("update value not loaded at period end");
    // Setting the mode register is held in the divider field on the next cycle.
    a_mode_write: assert property (wr_done && paddr == `FPWM_OFS_MODE |=> s.div_a == $past(pwdata[7:0]))
        else $error("mode register write lost");

endmodule : fpwm_top

// [hw/fpwm_defines.svh]
// Register offsets, field positions, reset values and counts of the four-channel waveform unit.
// Assumes inclusion by bare name from every file that decodes registers or fields.
`ifndef FPWM_DEFINES_SVH
`define FPWM_DEFINES_SVH

// Common register byte offsets.
`define FPWM_OFS_MODE 12'h000
`define FPWM_OFS_ENABLE 12'h004
`define FPWM_OFS_DISABLE 12'h008
`define FPWM_OFS_STATUS 12'h00c
`define FPWM_OFS_INT_EN 12'h010
`define FPWM_OFS_INT_DIS 12'h014
`define FPWM_OFS_INT_MASK 12'h018
`define FPWM_OFS_INT_STAT 12'h01c
// Channel block base, and word index of each channel register inside a block.
`define FPWM_CHAN_BASE_BITS 3'h1
`define FPWM_CH_MODE 3'h0
`define FPWM_CH_DUTY 3'h1
`define FPWM_CH_PERIOD 3'h2
`define FPWM_CH_COUNT 3'h3
`define FPWM_CH_UPDATE 3'h4
// Mode register field positions.
`define FPWM_DIV_A_LSB 0
`define FPWM_PRE_A_LSB 8
`define FPWM_DIV_B_LSB 16
`define FPWM_PRE_B_LSB 24
// Channel mode register field positions.
`define FPWM_CLK_SEL_LSB 0
`define FPWM_CENTER_BIT 8
`define FPWM_POL_BIT 9
`define FPWM_UPD_TGT_BIT 10
// Reset values.
`define FPWM_DIV_RST 8'h00
`define FPWM_PRE_RST 4'h0
`define FPWM_CLK_SEL_RST 4'h0
`define FPWM_WORD_RST 16'h0000
// Clock selector codes beyond the eleven prescaler taps.
`define FPWM_SEL_CLK_A 4'hb
`define FPWM_SEL_CLK_B 4'hc
// Number of binary prescaler stages, giving divide by 1024 at the top.
`define FPWM_PRE_STAGES 10

`endif

// [hw/fpwm_pkg.sv]
// Types shared by the waveform unit top and its channel module.
// Assumes the constants header supplies all numeric values.
package fpwm_pkg;

    // Counting direction of a channel, one-hot coded.
    typedef enum logic [1:0] {
        FPWM_UP = 2'b01,
        FPWM_DOWN = 2'b10
    } fpwm_dir_type;

    // Live configuration that a channel's counter and comparator read.
    typedef struct packed {
        logic enable;
        logic center;
        logic polarity;
        logic [15:0] period;
        logic [15:0] duty;
    } fpwm_chan_cfg_type;

    // Complete state of one channel.
    typedef struct packed {
        logic [15:0] count;
        fpwm_dir_type dir;
        logic wave;
    } fpwm_chan_state_type;

    // Complete register state of the unit top.
    typedef struct packed {
        logic [7:0] div_a;
        logic [3:0] pre_a;
        logic [7:0] div_b;
        logic [3:0] pre_b;
        logic [9:0] pre_count;
        logic [7:0] div_count_a;
        logic [7:0] div_count_b;
        logic [3:0] enabled;
        logic [3:0] int_mask;
        logic [3:0] int_stat;
        logic [3:0][3:0] clk_sel;
        logic [3:0] center;
        logic [3:0] polarity;
        logic [3:0] upd_target;
        logic [3:0][15:0] period;
        logic [3:0][15:0] duty;
        logic [3:0][15:0] upd_value;
        logic [3:0] upd_pending;
        logic [31:0] prdata;
        logic pslverr;
    } fpwm_regs_type;

endpackage : fpwm_pkg

// [hw/fpwm_channel.sv]
// One waveform channel: 16-bit counter, comparator and output flop.
// Assumes a one-cycle count tick from the clock selector and live configuration from the top.
`timescale 1ns/1ps
`include "fpwm_defines.svh"
module fpwm_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire fpwm_pkg::fpwm_chan_cfg_type cfg,
    output logic [15:0] count,
    output logic wave,
    output logic period_end
);

    // Registered state and its next value.
    fpwm_pkg::fpwm_chan_state_type s;
    fpwm_pkg::fpwm_chan_state_type next_s;

    // Counter stepping, period end detection and comparator.
    always_comb begin
        next_s = s;
        period_end = 1'b0;
        if (!cfg.enable) begin
            // Disabled channel holds at zero, counting up, at its idle level.
            next_s.count = `FPWM_WORD_RST;
            next_s.dir = fpwm_pkg::FPWM_UP;
        end else if (tick) begin
            if (!cfg.center) begin
                // Left aligned: 0 .. period-1, then wrap and close the period.
                if ({1'b0, s.count} + 17'h00001 >= {1'b0, cfg.period}) begin
                    next_s.count = `FPWM_WORD_RST;
                    period_end = 1'b1;
                end else begin
                    next_s.count = s.count + 16'h0001;
                end
            end else begin
                case (s.dir)
                    fpwm_pkg::FPWM_UP: begin
                        // Turn at the period value; a period of 0 or 1 closes at once.
                        if (s.count >= cfg.period) begin
                            if (s.count <= 16'h0001) begin
                                next_s.count = `FPWM_WORD_RST;
                                period_end = 1'b1;
                            end else begin
                                next_s.count = s.count - 16'h0001;
                                next_s.dir = fpwm_pkg::FPWM_DOWN;
                            end
                        end else begin
                            next_s.count = s.count + 16'h0001;
                        end
                    end
                    fpwm_pkg::FPWM_DOWN: begin
                        // Reaching zero on the way down closes the period.
                        if (s.count <= 16'h0001) begin
                            next_s.count = `FPWM_WORD_RST;
                            next_s.dir = fpwm_pkg::FPWM_UP;
                            period_end = 1'b1;
                        end else begin
                            next_s.count = s.count - 16'h0001;
                        end
                    end
                    default: begin
                        next_s.dir = fpwm_pkg::FPWM_UP;
                    end
                endcase
            end
        end
        // Start level while below duty; full duty pins the start level, zero duty the other.
        // On the way down the duty value itself counts too, so both halves hold duty ticks.
        if (!cfg.enable) begin
            next_s.wave = cfg.polarity;
        end else if (cfg.duty >= cfg.period || next_s.count < cfg.duty
            || (cfg.center && next_s.dir == fpwm_pkg::FPWM_DOWN && next_s.count == cfg.duty)) begin
            next_s.wave = cfg.polarity;
        end else begin
            next_s.wave = ~cfg.polarity;
        end
    end

    // State register; with no tick an enabled channel's whole state simply holds, so gating resumes cleanly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{count: 16'h0000, dir: fpwm_pkg::FPWM_UP, wave: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign count = s.count;
    assign wave = s.wave;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A left-aligned wrap always lands on zero and raises the period end.
    a_left_wrap_zero: assert property (cfg.enable && !cfg.center && tick && cfg.period != 16'h0000
        && count == cfg.period - 16'h0001 |-> period_end ##1 count == 16'h0000)
        else $error("left aligned counter did not wrap at period");
    // A disabled channel shows its polarity level on the next cycle.
    a_idle_level: assert property (!cfg.enable |=> wave == $past(cfg.polarity))
        else $error("disabled channel output not at idle level");
    // Zero duty with a nonzero period settles to the opposite of polarity.
    a_zero_duty_level: assert property (cfg.enable && cfg.duty == 16'h0000 && cfg.period != 16'h0000
        ##1 $stable(cfg) |-> wave == ~cfg.polarity)
        else $error("zero duty output not at opposite level");
    // Centered counting turns at the period and goes down.
    sequence s_top_turn;
        cfg.enable && cfg.center && tick && s.dir == fpwm_pkg::FPWM_UP && count == cfg.period
            && cfg.period > 16'h0001;
    endsequence
    a_center_turn: assert property (s_top_turn |=> s.dir == fpwm_pkg::FPWM_DOWN
        && count == $past(count) - 16'h0001)
        else $error("center aligned counter did not turn at period");
    // No tick, no movement.
    a_hold_no_tick: assert property (cfg.enable && !tick |=> $stable(count))
        else $error("counter moved without a tick");

endmodule : fpwm_channel

// [testbench/tb.sv]
// Self-checking bench for the four-channel waveform unit.
// Assumes the unit top, its package and its header under hw/.
`timescale 1ns/1ps
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, unit_clock_on = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd_d;
    logic pready, pslverr, irq, rd_e;
    logic [3:0] waveform_output;
    int err_count = 0, n_tests = 0, seed = 85, p, d, pol, cen, sel, pa, da, pb, db, s, h, e;
    always #25 pclk = ~pclk;
    fpwm_top i_fpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .unit_clock_on(unit_clock_on), .waveform_output(waveform_output), .irq(irq));
    // One APB transfer; read data and error are taken at the edge that samples pready high.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : xfer
    // Compares one value and counts it.
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task final_report;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // Cuts a hang short.
    initial begin
        #3000000;
        err_count++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        xfer(0, 12'h000, 0);
        chk(rd_d, 0);
        xfer(0, 12'h200, 0);
        chk(rd_d, 0);
        xfer(0, 12'h020, 0);
        chk(rd_e, 1);
        pa = {$random(seed)} % 2;
        da = 1 + {$random(seed)} % 3;
        pb = {$random(seed)} % 2;
        db = 1 + {$random(seed)} % 3;
        xfer(1, 12'h000, (pb << 24) | (db << 16) | (pa << 8) | da);
        xfer(0, 12'h000, 0);
        chk(rd_d, (pb << 24) | (db << 16) | (pa << 8) | da);
        // Random channel setups; high time over four whole periods is compared with the model.
        for (int i = 0; i < 6; i++) begin
            p = 2 + {$random(seed)} % 8;
            d = {$random(seed)} % (p + 1);
            pol = {$random(seed)} % 2;
            cen = {$random(seed)} % 2;
            sel = {$random(seed)} % 5;
            sel = (sel == 3) ? 11 : ((sel == 4) ? 12 : sel);
            s = (sel == 11) ? (1 << pa) * da : ((sel == 12) ? (1 << pb) * db : (1 << sel));
            xfer(1, 12'h008, 1);
            xfer(1, 12'h200, (pol << 9) | (cen << 8) | sel);
            xfer(1, 12'h204, d);
            xfer(1, 12'h208, p);
            xfer(1, 12'h004, 1);
            repeat (2 * p * s * (cen + 1)) @(posedge pclk);
            h = 0;
            repeat (4 * p * s * (cen + 1)) begin
                @(negedge pclk);
                h += waveform_output[0];
            end
            // Polarity level lasts duty ticks per period, or per half period when centered.
            chk(h, 4 * s * (cen + 1) * (pol ? d : p - d));
            @(posedge pclk);
        end
        unit_clock_on <= 0;
        xfer(1, 12'h010, 1);
        xfer(0, 12'h018, 0);
        chk(rd_d, 1);
        xfer(0, 12'h20c, 0);
        h = rd_d;
        repeat (50) @(posedge pclk);
        xfer(0, 12'h20c, 0);
        chk(rd_d, h);
        unit_clock_on <= 1;
        xfer(0, 12'h01c, 0);
        repeat (8 * p * s) @(posedge pclk);
        chk(irq, 1);
        xfer(0, 12'h01c, 0);
        chk(rd_d[0], 1);
        xfer(1, 12'h200, ((1 - pol) << 9) | sel);
        xfer(0, 12'h200, 0);
        chk(rd_d[9], pol[0]);
        xfer(1, 12'h008, 1);
        xfer(1, 12'h200, 32'h200);
        @(negedge pclk);
        chk(waveform_output, 4'h1);
        @(posedge pclk);
        // A running channel takes a new duty only through the update register, at its period end.
        e = (d + 1) % (p + 1);
        xfer(1, 12'h004, 1);
        xfer(1, 12'h210, e);
        repeat (2 * p) @(posedge pclk);
        xfer(0, 12'h204, 0);
        chk(rd_d, e);
        xfer(1, 12'h008, 1);
        xfer(0, 12'h00c, 0);
        chk(rd_d, 0);
        xfer(1, 12'h014, 1);
        xfer(0, 12'h018, 0);
        chk(rd_d, 0);
        chk(irq, 0);
        final_report;
    end
endmodule : tb
